/* hdl/reset_ctl_defs.svh */
`ifndef RESET_CTL_DEFS_SVH
`define RESET_CTL_DEFS_SVH
// register addresses (I/O ports and config region offsets)
`define ADDR_CMD_DATA     12'h060
`define ADDR_CMD_PORT     12'h064
`define ADDR_PORT_A       12'h092
`define ADDR_RESET_CFG    12'hD72
`define ADDR_RESET_STA    12'hD74
// legacy command codes
`define CMD_SOFT_RESET    8'hFE
`define CMD_A20_WRITE     8'hD1
// field positions
`define PA_CPU_RST        0
`define PA_A20            1
`define CD_A20            1
`define CFG_SOFTWARE_SYSTEM_RESET_BIT       0
`define CFG_LB_RST        1
`define CFG_DBG_ON_RST    2
`define CFG_KEEP_EN       3
`define ST_DBG_HARD       0
`define ST_DBG_SYS        1
`define ST_WDT            2
`define ST_SHUTDOWN       3
`define ST_RETAIN         4
`define ST_POWER_GOOD_PIN        5
// reset values
`define PORT_A_RESET      8'h00
`define RESET_CFG_RESET   8'h00
`define RESET_STA_RESET   8'h00
// timing
`define CLK_NS            20
`define PLL_WAIT_MS       10
`define PLL_WAIT_CYC      ((`PLL_WAIT_MS * 1000000) / `CLK_NS)
`define SOFT_RST_CYC      16
`define ARB_MAX_CYC       32
`endif

/* hdl/reset_ctl_pkg.sv */
package reset_ctl_pkg;
    typedef logic [11:0] addr_t;
    typedef logic [7:0]  byte_t;
    typedef enum logic [1:0]
    {
        SEQ_RUN  = 2'b00,
        SEQ_ARB  = 2'b01,
        SEQ_HOLD = 2'b10,
        SEQ_PLL  = 2'b11
    } seq_state_t;
endpackage

/* hdl/reset_source_and_a20_control.sv */
`timescale 1ns/1ps
`include "reset_ctl_defs.svh"

// How it works
// - retention enabled plus power good: pin, software, watchdog, debug system resets keep SDRAM.
// - retention resets skip latching straps and board data; else normal reset.
// - retention request waits for SDRAM controller idle acknowledge before reset asserts.
// - no acknowledge in time: normal system reset, retention enable bit cleared.
// - request-to-reset arbitration delay at most 32 clocks.
// - soft reset keeps registers except NMI enable; no local bus or PCI reset.
// - soft reset line to CPU held for 16 cycles.
// - every write of 1 to port A soft bit triggers; bit stays until cleared.
// - command FEh to legacy command port triggers soft reset.
// - CPU shutdown cycle from triple fault triggers soft reset.
// - debug soft reset command triggers soft reset; debug-on-reset enters debug mode.
// - local bus reset pin follows system reset or software bit.
// - PCI reset pin follows system reset or host bridge PCI reset bit.
// - low battery sense on power-good reset gives RTC reset and sets valid bit.
// - six reset-source status bits set on event, cleared by writing 1.
// - command a20 and port A a20 are ORed, then gated by CPU a20; low when both clear or CPU a20 low.
// - D1h command then data write loads data bit 1 as emulated a20.
// - port A a20 bit passes a20 when set; reset default clear.
// - system reset restarts PLLs; wait 10 ms before releasing internal resets.
// - system reset discards cache, SDRAM write buffer and PCI queues.
// - resets held while power good low, except during retention arbitration; straps and board data latched on assertion.
// - power-on: CPU and external resets released 10 ms after power good.
// - local bus and PCI reset pins held through whole PLL interval.
module reset_source_and_a20_control
#(
    parameter int PLL_WAIT = `PLL_WAIT_CYC,
    parameter int ARB_MAX  = `ARB_MAX_CYC
)
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    // register access port
    input  wire logic                regWr,
    input  wire logic                regRd,
    input  wire reset_ctl_pkg::addr_t regAddr,
    input  wire reset_ctl_pkg::byte_t regWdata,
    output logic [7:0]               regRdata,
    // board pins
    input  wire logic                powerGoodPin,
    input  wire logic                retentionResetPin,
    input  wire logic [3:0]          strapConfigPins,
    input  wire logic [7:0]          boardDataPins,
    input  wire logic                backupBatteryLow,
    output logic                     localBusResetPin,
    output logic                     pciResetPin,
    // other on-chip sources
    input  wire logic                watchdogSysReset,
    input  wire logic                debugSysReset,
    input  wire logic                debugHardReset,
    input  wire logic                debugSoftReset,
    input  wire logic                cpuShutdown,
    input  wire logic                hostBridgePciResetBit,
    input  wire logic                cpuA20,
    // SDRAM controller handshake
    output logic                     sdramKeepReq,
    input  wire logic                sdramIdleAck,
    output logic                     sdramKeepConfig,
    // reset and control outputs
    output logic                     cpuHardReset,
    output logic                     cpuSoftReset,
    output logic                     regReset,
    output logic                     pllRestart,
    output logic                     discardBuffers,
    output logic                     nmiEnableClear,
    output logic                     debugModeEnter,
    output logic                     rtcReset,
    output logic                     rtcContentsValidSet,
    output logic                     a20Out,
    output logic [3:0]               strapConfigLatched,
    output logic [7:0]               boardDataLatched
);
    import reset_ctl_pkg::*;

    localparam logic [4:0] SOFT_LAST = 5'(`SOFT_RST_CYC - 1);

    seq_state_t  state_ff;
    seq_state_t  nxt_state;
    logic [31:0] pllCnt_ff;
    logic [5:0]  arbCnt_ff;
    logic [4:0]  softCnt_ff;
    logic        softActive_ff;
    logic        keepReset_ff;
    logic        pgSrc_ff;
    logic        pgMeta_ff;
    logic        pgSync_ff;
    logic        pgPrev_ff;
    logic        rpMeta_ff;
    logic        rpSync_ff;
    logic        rpPrev_ff;
    logic        cmdD1_ff;
    logic        a20Cmd_ff;
    logic        dbgPend_ff;
    logic [7:0]  portA_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  sta_ff;
    logic        rtcValid_ff;

    // two-flop synchronisers; first stage is read only by the second
    always_ff @(posedge sys_clk)
    begin
        pgMeta_ff <= powerGoodPin;
        pgSync_ff <= pgMeta_ff;
        rpMeta_ff <= retentionResetPin;
        rpSync_ff <= rpMeta_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pgPrev_ff <= 1'b0;
            rpPrev_ff <= 1'b0;
        end
        else
        begin
            pgPrev_ff <= pgSync_ff;
            rpPrev_ff <= rpSync_ff;
        end
    end

    // decoded write strobes
    logic wrData, wrCmd, wrPortA, wrCfg, wrSta;
    assign wrData  = regWr && (regAddr == `ADDR_CMD_DATA);
    assign wrCmd   = regWr && (regAddr == `ADDR_CMD_PORT);
    assign wrPortA = regWr && (regAddr == `ADDR_PORT_A);
    assign wrCfg   = regWr && (regAddr == `ADDR_RESET_CFG);
    assign wrSta   = regWr && (regAddr == `ADDR_RESET_STA);

    // system reset causes other than power good
    logic pinReq, swReq, sysReq, pgRise, inRun;
    assign inRun  = (state_ff == SEQ_RUN);
    assign pinReq = rpSync_ff && !rpPrev_ff && cfg_ff[`CFG_KEEP_EN];
    assign swReq  = wrCfg && regWdata[`CFG_SOFTWARE_SYSTEM_RESET_BIT];
    assign sysReq = pinReq || swReq || watchdogSysReset || debugSysReset;
    assign pgRise = pgSync_ff && !pgPrev_ff;

    // sequencer: arbitration, held reset, PLL wait
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SEQ_RUN:
            begin
                if (!pgSync_ff)
                    nxt_state = SEQ_HOLD;
                else if (sysReq && cfg_ff[`CFG_KEEP_EN])
                    nxt_state = SEQ_ARB;
                else if (sysReq)
                    nxt_state = SEQ_PLL;
            end
            SEQ_ARB:
            begin
                if (sdramIdleAck || arbCnt_ff == 6'(ARB_MAX - 1))
                    nxt_state = SEQ_PLL;
            end
            SEQ_HOLD:
            begin
                if (pgSync_ff)
                    nxt_state = SEQ_PLL;
            end
            SEQ_PLL:
            begin
                if (!pgSync_ff)
                    nxt_state = SEQ_HOLD;
                else if (pllCnt_ff == 32'(PLL_WAIT - 1))
                    nxt_state = SEQ_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            state_ff <= SEQ_HOLD;
        else
            state_ff <= nxt_state;
    end

    // arbitration and PLL interval counters
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            arbCnt_ff <= 6'h00;
            pllCnt_ff <= 32'h0000_0000;
        end
        else
        begin
            arbCnt_ff <= (state_ff == SEQ_ARB) ? arbCnt_ff + 6'h01 : 6'h00;
            pllCnt_ff <= (state_ff == SEQ_PLL) ? pllCnt_ff + 32'h1 : 32'h0;
        end
    end

    // retention flavour and power-good origin of the current reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            keepReset_ff <= 1'b0;
            pgSrc_ff     <= 1'b1;
        end
        else if (state_ff == SEQ_HOLD)
        begin
            keepReset_ff <= 1'b0;
            pgSrc_ff     <= 1'b1;
        end
        else if (state_ff == SEQ_ARB && nxt_state == SEQ_PLL)
        begin
            keepReset_ff <= sdramIdleAck;
            pgSrc_ff     <= 1'b0;
        end
        else if (inRun && sysReq)
        begin
            keepReset_ff <= 1'b0;
            pgSrc_ff     <= 1'b0;
        end
    end

    // straps latched only when power good asserts
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            strapConfigLatched <= 4'h0;
            boardDataLatched   <= 8'h00;
        end
        else if (state_ff == SEQ_HOLD && pgSync_ff)
        begin
            strapConfigLatched <= strapConfigPins;
            boardDataLatched   <= boardDataPins;
        end
    end

    // reset configuration; a failed arbitration clears the retention enable
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            cfg_ff <= `RESET_CFG_RESET;
        else if (state_ff == SEQ_ARB && nxt_state == SEQ_PLL && !sdramIdleAck)
            cfg_ff[`CFG_KEEP_EN] <= 1'b0;
        else if (wrCfg)
        begin
            cfg_ff                  <= regWdata;
            cfg_ff[`CFG_SOFTWARE_SYSTEM_RESET_BIT]    <= 1'b0;                               // self-clearing trigger
        end
        else if (state_ff == SEQ_HOLD)
            cfg_ff <= `RESET_CFG_RESET;
        else if (state_ff == SEQ_PLL && !keepReset_ff)
            cfg_ff <= {cfg_ff[7:4], cfg_ff[`CFG_KEEP_EN], 3'b000};         // keep enable, drop local reset
    end

    // port A: soft bit stays until written 0; a20 bit default clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !inRun)
            portA_ff <= `PORT_A_RESET;
        else if (wrPortA)
            portA_ff <= regWdata;
    end

    // legacy command emulation: D1h arms the next data write
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !inRun)
        begin
            cmdD1_ff  <= 1'b0;
            a20Cmd_ff <= 1'b0;
        end
        else if (wrCmd)
            cmdD1_ff <= (regWdata == `CMD_A20_WRITE);
        else if (wrData && cmdD1_ff)
        begin
            a20Cmd_ff <= regWdata[`CD_A20];
            cmdD1_ff  <= 1'b0;
        end
    end

    // soft reset triggers from four sources
    logic softTrig;
    assign softTrig = inRun && ((wrPortA && regWdata[`PA_CPU_RST])
                    || (wrCmd && regWdata == `CMD_SOFT_RESET)
                    || cpuShutdown
                    || debugSoftReset);

    // 16-cycle soft reset pulse; retrigger restarts the count
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !inRun)
        begin
            softActive_ff <= 1'b0;
            softCnt_ff    <= 5'h00;
        end
        else if (softTrig)
        begin
            softActive_ff <= 1'b1;
            softCnt_ff    <= 5'h00;
        end
        else if (softActive_ff)
        begin
            softCnt_ff    <= softCnt_ff + 5'h01;
            softActive_ff <= (softCnt_ff != SOFT_LAST);
        end
    end

    // debug mode request after a debug soft reset ends
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !inRun)
            dbgPend_ff <= 1'b0;
        else if (debugSoftReset)
            dbgPend_ff <= cfg_ff[`CFG_DBG_ON_RST];
        else if (!softActive_ff)
            dbgPend_ff <= 1'b0;
    end

    // status bits: event set wins over write-1 clear
    logic [7:0] staSet;
    always_comb
    begin
        staSet                 = 8'h00;
        staSet[`ST_DBG_HARD]   = debugHardReset;
        staSet[`ST_DBG_SYS]    = inRun && debugSysReset;
        staSet[`ST_WDT]        = inRun && watchdogSysReset;
        staSet[`ST_SHUTDOWN]   = inRun && cpuShutdown;
        staSet[`ST_RETAIN]     = inRun && pinReq;
        staSet[`ST_POWER_GOOD_PIN]    = pgRise;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            sta_ff <= `RESET_STA_RESET;
        else
            sta_ff <= ((wrSta ? sta_ff & ~regWdata : sta_ff) | staSet) & 8'h3F;
    end

    // RTC reset when battery low on a power-good reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rtcReset <= 1'b0;
        else
            rtcReset <= (state_ff == SEQ_PLL) && pgSrc_ff && backupBatteryLow;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rtcValid_ff <= 1'b0;
        else
            rtcValid_ff <= rtcReset;
    end

    // reset outputs; soft reset never touches pins
    logic sysRstActive;
    assign sysRstActive        = (state_ff == SEQ_HOLD) || (state_ff == SEQ_PLL);
    assign cpuHardReset        = sysRstActive;
    assign regReset            = sysRstActive;                             // retention spares SDRAM setup and the reset configuration register
    assign pllRestart          = sysRstActive;
    assign discardBuffers      = sysRstActive;
    assign localBusResetPin    = sysRstActive || cfg_ff[`CFG_LB_RST];
    assign pciResetPin         = sysRstActive || hostBridgePciResetBit;
    assign sdramKeepReq        = (state_ff == SEQ_ARB);
    assign sdramKeepConfig     = keepReset_ff;
    assign cpuSoftReset        = softActive_ff;
    assign nmiEnableClear      = softActive_ff;
    assign debugModeEnter      = dbgPend_ff && !softActive_ff;
    assign rtcContentsValidSet = rtcValid_ff;
    assign a20Out              = cpuA20 && (a20Cmd_ff || portA_ff[`PA_A20]);

    // read data registered, unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !regRd)
            regRdata <= 8'h00;
        else if (regAddr == `ADDR_PORT_A)
            regRdata <= portA_ff;
        else if (regAddr == `ADDR_RESET_CFG)
            regRdata <= cfg_ff;
        else if (regAddr == `ADDR_RESET_STA)
            regRdata <= sta_ff;
        else
            regRdata <= 8'h00;
    end
endmodule

/* sim/sdram_idle_model.sv */
`timescale 1ns/1ps
module sdram_idle_model
(
    // clock
    input  wire logic sys_clk,
    // keep request handshake and test knobs
    input  wire logic        sdramKeepReq,
    input  wire logic        ackOn,
    input  wire logic [31:0] ackDelay,
    output logic             sdramIdleAck
);
    int waitCnt = 0;

    // count ackDelay cycles of standing request, then acknowledge while the request stands;
    // ackOn low models a controller that never answers
    always_ff @(posedge sys_clk)
    begin
        waitCnt      <= sdramKeepReq ? waitCnt + 1 : 0;
        sdramIdleAck <= sdramKeepReq && ackOn && (waitCnt >= ackDelay);
    end
endmodule

/* sim/reset_ctl_properties.sv */
`timescale 1ns/1ps
`include "reset_ctl_defs.svh"
module reset_ctl_properties
#(
    parameter int PLL_WAIT = 50
)
(
    // clock, reset and register writes
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 regWr,
    input  wire reset_ctl_pkg::addr_t regAddr,
    input  wire reset_ctl_pkg::byte_t regWdata,
    // pins and side inputs
    input  wire logic                 powerGoodPin,
    input  wire logic                 hostBridgePciResetBit,
    input  wire logic                 cpuA20,
    input  wire logic                 sdramKeepReq,
    input  wire logic                 sdramIdleAck,
    // observed outputs
    input  wire logic                 sdramKeepConfig,
    input  wire logic                 cpuHardReset,
    input  wire logic                 cpuSoftReset,
    input  wire logic                 nmiEnableClear,
    input  wire logic                 regReset,
    input  wire logic                 pllRestart,
    input  wire logic                 discardBuffers,
    input  wire logic                 localBusResetPin,
    input  wire logic                 pciResetPin,
    input  wire logic                 a20Out
);
    import reset_ctl_pkg::*;
    logic [31:0] holdCnt;
    logic        runOk;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // port A and legacy command and data writes only act in normal running, not while arbitrating or in reset
    assign runOk = !cpuHardReset && !sdramKeepReq;

    // length of the current system reset, to prove the PLL wait
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            holdCnt <= '0;
        else
            holdCnt <= cpuHardReset ? holdCnt + 32'h1 : '0;
    end

    chk_soft_length: assert property ($rose(cpuSoftReset) |-> cpuSoftReset[*8] ##1 cpuSoftReset[*8] ##1 !cpuSoftReset)
        else $error("soft reset pulse not 16 cycles");
    chk_soft_cause: assert property (regWr && runOk && ((regAddr == `ADDR_PORT_A && regWdata[`PA_CPU_RST])
        || (regAddr == `ADDR_CMD_PORT && regWdata == `CMD_SOFT_RESET)) |=> cpuSoftReset)
        else $error("soft reset write gave no soft reset");
    chk_soft_nmi: assert property (cpuSoftReset |-> nmiEnableClear && (pciResetPin == hostBridgePciResetBit))
        else $error("soft reset without nmi clear or with pci reset");
    chk_arb_bound: assert property ($rose(sdramKeepReq) |-> ##[1:33] cpuHardReset)
        else $error("arbitration took too long");
    chk_keep_config: assert property (sdramKeepReq && sdramIdleAck |-> ##[1:2] (sdramKeepConfig && cpuHardReset))
        else $error("acknowledged keep reset lost sdram setup");
    chk_pg_hold: assert property (!powerGoodPin [*4] |-> cpuHardReset)
        else $error("reset released while power good low");
    chk_pll_wait: assert property ($fell(cpuHardReset) |-> holdCnt >= PLL_WAIT)
        else $error("reset released before pll wait");
    chk_sys_outputs: assert property (cpuHardReset |-> localBusResetPin && pllRestart && discardBuffers && regReset)
        else $error("system reset outputs incomplete");
    chk_pci_follow: assert property (pciResetPin == (cpuHardReset || hostBridgePciResetBit))
        else $error("pci reset pin mismatch");
    chk_a20_pass: assert property (regWr && runOk && regAddr == `ADDR_PORT_A && regWdata[`PA_A20] |=> a20Out == cpuA20)
        else $error("port a a20 bit did not pass a20");
    chk_a20_low: assert property (!cpuA20 |-> !a20Out)
        else $error("a20 high without cpu a20");
endmodule

bind reset_source_and_a20_control reset_ctl_properties #(.PLL_WAIT(PLL_WAIT)) u_props
(
    .sys_clk, .rst_b, .regWr, .regAddr, .regWdata, .powerGoodPin, .hostBridgePciResetBit, .cpuA20,
    .sdramKeepReq, .sdramIdleAck, .sdramKeepConfig, .cpuHardReset, .cpuSoftReset, .nmiEnableClear,
    .regReset, .pllRestart, .discardBuffers, .localBusResetPin, .pciResetPin, .a20Out
);

/* sim/tb_reset_source_and_a20_control.sv */
`timescale 1ns/1ps
`include "reset_ctl_defs.svh"
module tb_reset_source_and_a20_control;
    import reset_ctl_pkg::*;
    localparam int PLL_WAIT = 50;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    addr_t       regAddr = '0;
    byte_t       regWdata = '0;
    logic        powerGoodPin = 1'b0;
    logic        retentionResetPin = 1'b0;
    logic [3:0]  strapConfigPins = 4'hA;
    logic [7:0]  boardDataPins = 8'h5C;
    logic        backupBatteryLow = 1'b1;
    logic [4:0]  ev = '0; // shutdown, dbg soft, wdt, dbg sys, dbg hard
    logic        hostBridgePciResetBit = 1'b0;
    logic        cpuA20 = 1'b1;
    logic        ackOn = 1'b1;
    int          ackDelay = 5;
    logic [7:0]  regRdata, boardDataLatched;
    logic [3:0]  strapConfigLatched;
    logic        localBusResetPin, pciResetPin, sdramKeepReq, sdramIdleAck, sdramKeepConfig, cpuHardReset;
    logic        cpuSoftReset, regReset, pllRestart, discardBuffers, nmiEnableClear, debugModeEnter;
    logic        rtcReset, rtcContentsValidSet, a20Out, rtcSeen, rtcVal, dbgSeen;
    int          fails = 0;
    int          total_checks = 0;
    int          softCnt = 0;
    int          n;

    reset_source_and_a20_control #(.PLL_WAIT(PLL_WAIT)) u_dut
    (
        .sys_clk, .rst_b, .regWr, .regRd, .regAddr, .regWdata, .regRdata, .powerGoodPin, .retentionResetPin,
        .strapConfigPins, .boardDataPins, .backupBatteryLow, .localBusResetPin, .pciResetPin,
        .watchdogSysReset(ev[2]), .debugSysReset(ev[3]), .debugHardReset(ev[4]), .debugSoftReset(ev[1]),
        .cpuShutdown(ev[0]), .hostBridgePciResetBit, .cpuA20, .sdramKeepReq, .sdramIdleAck, .sdramKeepConfig,
        .cpuHardReset, .cpuSoftReset, .regReset, .pllRestart, .discardBuffers, .nmiEnableClear, .debugModeEnter,
        .rtcReset, .rtcContentsValidSet, .a20Out, .strapConfigLatched, .boardDataLatched
    );

    sdram_idle_model u_sdram (.sys_clk, .sdramKeepReq, .ackOn, .ackDelay, .sdramIdleAck);

    // free-running clock
    always #10 sys_clk = ~sys_clk;

    // sticky monitors; pulse lengths are counted here so task timing cannot skew them
    always @(posedge sys_clk)
    begin
        if (cpuSoftReset) softCnt++;
        if (rtcReset) rtcSeen = 1'b1;
        if (rtcContentsValidSet) rtcVal = 1'b1;
        if (debugModeEnter) dbgSeen = 1'b1;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every access task starts and ends on a falling edge, one idle cycle after
    task wr(input addr_t a, input byte_t d);
        regWr = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge sys_clk);
        regWr = 1'b0;
        @(negedge sys_clk);
    endtask

    task rd(input addr_t a, input byte_t exp);
        regRd = 1'b1;
        regAddr = a;
        @(negedge sys_clk);
        regRd = 1'b0;
        chk(regRdata, exp);
        @(negedge sys_clk);
    endtask

    task pulse(input int i);
        ev[i] = 1'b1;
        @(negedge sys_clk);
        ev[i] = 1'b0;
        @(negedge sys_clk);
    endtask

    task wait_hard;
        n = 0;
        while (!cpuHardReset && n < 60)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(cpuHardReset, 1);
    endtask

    task wait_run;
        n = 0;
        while ((cpuHardReset || sdramKeepReq) && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(cpuHardReset || sdramKeepReq, 0);
    endtask

    task end_sim;
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #400000;
        fails++;
        end_sim;
    end

    initial
    begin
        {rtcSeen, rtcVal, dbgSeen} = 3'b000;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk({cpuHardReset, localBusResetPin, pciResetPin}, 3'b111);
        powerGoodPin = 1'b1;
        wait_run;
        chk(n >= PLL_WAIT, 1);
        strapConfigPins = 4'h3;
        boardDataPins = 8'hA7;
        chk({strapConfigLatched, boardDataLatched}, 12'hA5C);
        chk({rtcSeen, rtcVal}, 2'b11);
        rd(`ADDR_RESET_CFG, `RESET_CFG_RESET);
        rd(`ADDR_PORT_A, `PORT_A_RESET);
        rd(`ADDR_RESET_STA, 8'h20);
        wr(`ADDR_RESET_STA, 8'h20);
        rd(`ADDR_RESET_STA, 8'h00);
        rd(12'h0F0, 8'h00);
        // a20 sources
        chk(a20Out, 0);
        wr(`ADDR_CMD_PORT, `CMD_A20_WRITE);
        wr(`ADDR_CMD_DATA, 8'h02);
        chk(a20Out, 1);
        wr(`ADDR_CMD_PORT, `CMD_A20_WRITE);
        wr(`ADDR_CMD_DATA, 8'h00);
        chk(a20Out, 0);
        wr(`ADDR_PORT_A, 8'h02);
        chk(a20Out, 1);
        cpuA20 = 1'b0;
        @(negedge sys_clk);
        chk(a20Out, 0);
        cpuA20 = 1'b1;
        wr(`ADDR_PORT_A, 8'h00);
        // software-held external resets
        wr(`ADDR_RESET_CFG, 8'h02);
        chk(localBusResetPin, 1);
        wr(`ADDR_RESET_CFG, 8'h04);
        chk(localBusResetPin, 0);
        hostBridgePciResetBit = 1'b1;
        @(negedge sys_clk);
        chk(pciResetPin, 1);
        hostBridgePciResetBit = 1'b0;
        // four soft reset sources, port A written twice while its bit stays set
        for (int k = 0; k < 5; k++)
        begin
            softCnt = 0;
            case (k)
                1: wr(`ADDR_CMD_PORT, `CMD_SOFT_RESET);
                2: pulse(0);
                3: pulse(1);
                default: wr(`ADDR_PORT_A, 8'h01);
            endcase
            n = 0;
            while ((softCnt == 0 || cpuSoftReset) && n < 40)
            begin
                @(negedge sys_clk);
                n++;
            end
            chk(softCnt, 16);
            chk({localBusResetPin, pciResetPin}, 2'b00);
        end
        chk(dbgSeen, 1);
        rd(`ADDR_PORT_A, 8'h01);
        wr(`ADDR_PORT_A, 8'h00);
        rd(`ADDR_RESET_STA, 8'h08);
        wr(`ADDR_RESET_STA, 8'hFF);
        // retention reset, acknowledged
        wr(`ADDR_RESET_CFG, 8'h08);
        rtcSeen = 1'b0;
        retentionResetPin = 1'b1;
        wait_hard;
        chk(sdramKeepConfig, 1);
        retentionResetPin = 1'b0;
        wait_run;
        chk({strapConfigLatched, boardDataLatched, rtcSeen}, 13'h14B8);
        rd(`ADDR_RESET_CFG, 8'h08);
        rd(`ADDR_RESET_STA, 8'h10);
        wr(`ADDR_RESET_STA, 8'hFF);
        // retention reset never acknowledged falls back to a normal one
        ackOn = 1'b0;
        pulse(2);
        wait_hard;
        chk(sdramKeepConfig, 0);
        wait_run;
        rd(`ADDR_RESET_CFG, 8'h00);
        rd(`ADDR_RESET_STA, 8'h04);
        wr(`ADDR_RESET_STA, 8'hFF);
        pulse(3);
        wait_hard;
        wait_run;
        rd(`ADDR_RESET_STA, 8'h02);
        wr(`ADDR_RESET_STA, 8'hFF);
        // debug hard reset only records its status
        pulse(4);
        rd(`ADDR_RESET_STA, 8'h01);
        wr(`ADDR_RESET_STA, 8'hFF);
        // software system reset bit gives a normal reset and clears itself
        wr(`ADDR_RESET_CFG, 8'h01);
        wait_hard;
        wait_run;
        rd(`ADDR_RESET_CFG, 8'h00);
        // power good lost mid-run relatches the new straps
        powerGoodPin = 1'b0;
        wait_hard;
        repeat (4) @(negedge sys_clk);
        powerGoodPin = 1'b1;
        wait_run;
        chk({strapConfigLatched, boardDataLatched}, 12'h3A7);
        end_sim;
    end
endmodule
